// ===== src/dsq_consts.vh
// constants for the debug state3 sequencer and banked comparator window
//
// Notes on behaviour
// - in state3 the 4-bit next code picks the target of a match
// - simultaneous matches: lowest numbered channel wins
// - a match leading to final state beats every other match, but not a disarm write
// - codes 0000/0001/0010: any match goes to state1/state2/final
// - codes 0011/0100/0101: only channel 0 acts, to state1/state2/final
// - codes 0110/0111/1000: only channel 1 acts, to state1/state2/final
// - code 1001: channel 2 to state2, channel 0 to final
// - code 1010: channel 1 to state1, channel 3 to state2
// - code 1011: channel 3 to state2, channel 1 to final
// - code 1100: channel 2 to final; code 1101: channel 3 to final
// - all comparator banks share one 8-byte register window
// - comparators A and C: 3 address, 2 data, 2 mask, 1 control byte
// - comparators B and D: 3 address bytes and a different control byte
// - view-select field in debug control one picks the visible bank
// - for B or D the four data and mask bytes read zero, ignore writes
// - view 10 shows C and state3 control at 0x27; 11 shows D and flags
`ifndef DSQ_CONSTS_VH
`define DSQ_CONSTS_VH

// register byte addresses
`define DSQ_ADDR_CTRL1 8'h20
`define DSQ_ADDR_ARM 8'h21
`define DSQ_ADDR_STATE 8'h22
`define DSQ_ADDR_IRQ_STAT 8'h23
`define DSQ_ADDR_IRQ_EN 8'h24
`define DSQ_ADDR_IRQ_CLR 8'h25
`define DSQ_ADDR_SCR3 8'h27
`define DSQ_ADDR_WIN_BASE 8'h28
`define DSQ_ADDR_WIN_LAST 8'h2F

// window byte offsets from the base
`define DSQ_WIN_CTL 3'h0
`define DSQ_WIN_ADDR_HI 3'h1
`define DSQ_WIN_ADDR_MD 3'h2
`define DSQ_WIN_ADDR_LO 3'h3
`define DSQ_WIN_DATA_HI 3'h4
`define DSQ_WIN_DATA_LO 3'h5
`define DSQ_WIN_MASK_HI 3'h6
`define DSQ_WIN_MASK_LO 3'h7

// field positions
`define DSQ_CTRL1_VIEW_LSB 0
`define DSQ_CTL_EN_BIT 0
`define DSQ_CTL_DATA_BIT 1
`define DSQ_CTL_RW_BIT 2
`define DSQ_CTL_RWE_BIT 3
`define DSQ_CTLBD_MASK 8'h0D
`define DSQ_CTLAC_MASK 8'h0F

// reset values
`define DSQ_RST_BYTE 8'h00
`define DSQ_RST_SCR3 4'h0

// interrupt status bits
`define DSQ_IRQ_FINAL 0
`define DSQ_IRQ_MATCH 1

// sequencer state codes (one-hot)
`define DSQ_ST_IDLE 5'h01
`define DSQ_ST_S1 5'h02
`define DSQ_ST_S2 5'h04
`define DSQ_ST_S3 5'h08
`define DSQ_ST_FINAL 5'h10

`endif

// ===== src/dsq_seq.v
// debug trigger sequencer state3 selection with banked comparator window
`timescale 1ns/1ps
`default_nettype none
`include "dsq_consts.vh"

module dsq_seq #(
    parameter AW = 24,
    parameter DW = 16
) (
    // clock, reset, enable
    input wire i_mclk,
    input wire i_rst_n,
    input wire i_ce,
    // register port
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    // observed bus
    input wire i_bus_valid,
    input wire [AW-1:0] i_bus_addr,
    input wire [DW-1:0] i_bus_data,
    input wire i_bus_rnw,
    // sequencer state and events
    output wire [4:0] o_state,
    output wire o_final,
    output wire o_irq
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    reg [7:0] ctrl1_reg;
    reg [3:0] scr3_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [3:0] flags_reg;
    reg [1:0] irq_stat_reg;
    reg [1:0] irq_en_reg;
    reg [7:0] ctl_reg [0:3];
    reg [AW-1:0] cadr_reg [0:3];
    reg [DW-1:0] cdat_reg [0:1];
    reg [DW-1:0] cmsk_reg [0:1];

    wire [1:0] view = ctrl1_reg[`DSQ_CTRL1_VIEW_LSB+1:`DSQ_CTRL1_VIEW_LSB];
    wire view_ac = ~view[0]; // A=00, C=10 carry data compare
    wire win_hit = (i_addr >= `DSQ_ADDR_WIN_BASE) && (i_addr <= `DSQ_ADDR_WIN_LAST);
    wire [2:0] woff = i_addr[2:0];
    wire ac_idx = view[1]; // data bank index: A=0, C=1

    ////////////////////////////////////////////////////////////////////////
    // comparators: address match, optional data compare on A and C
    reg [3:0] match;
    integer k;
    always @* begin
        for (k = 0; k < 4; k = k + 1) begin
            match[k] = i_bus_valid && ctl_reg[k][`DSQ_CTL_EN_BIT]
                && (cadr_reg[k] == i_bus_addr)
                && (!ctl_reg[k][`DSQ_CTL_RWE_BIT]
                    || (ctl_reg[k][`DSQ_CTL_RW_BIT] == i_bus_rnw));
            // data compare exists only on A (0) and C (2)
            if (k == 0 || k == 2) begin
                if (ctl_reg[k][`DSQ_CTL_DATA_BIT] &&
                    (((i_bus_data ^ cdat_reg[k/2]) & cmsk_reg[k/2]) != {DW{1'b0}}))
                    match[k] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state3 next state decode; final targets checked first
    reg [4:0] s3_target;
    always @* begin
        s3_target = `DSQ_ST_S3;
        case (scr3_reg)
            4'h0: if (|match) s3_target = `DSQ_ST_S1;
            4'h1: if (|match) s3_target = `DSQ_ST_S2;
            4'h2: if (|match) s3_target = `DSQ_ST_FINAL;
            4'h3: if (match[0]) s3_target = `DSQ_ST_S1;
            4'h4: if (match[0]) s3_target = `DSQ_ST_S2;
            4'h5: if (match[0]) s3_target = `DSQ_ST_FINAL;
            4'h6: if (match[1]) s3_target = `DSQ_ST_S1;
            4'h7: if (match[1]) s3_target = `DSQ_ST_S2;
            4'h8: if (match[1]) s3_target = `DSQ_ST_FINAL;
            4'h9: begin
                // channel 0 is lower and leads to final, so it wins twice over
                if (match[0]) s3_target = `DSQ_ST_FINAL;
                else if (match[2]) s3_target = `DSQ_ST_S2;
            end
            4'hA: begin
                if (match[1]) s3_target = `DSQ_ST_S1;
                else if (match[3]) s3_target = `DSQ_ST_S2;
            end
            4'hB: begin
                if (match[1]) s3_target = `DSQ_ST_FINAL;
                else if (match[3]) s3_target = `DSQ_ST_S2;
            end
            4'hC: if (match[2]) s3_target = `DSQ_ST_FINAL;
            4'hD: if (match[3]) s3_target = `DSQ_ST_FINAL;
            default: s3_target = `DSQ_ST_S3; // reserved codes hold
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer; states 1 and 2 step on any match (kept simple here)
    wire arm_wr = i_wr && (i_addr == `DSQ_ADDR_ARM);
    always @* begin
        state_next = state_reg;
        case (state_reg)
            `DSQ_ST_IDLE: if (arm_wr && i_wdata[0]) state_next = `DSQ_ST_S1;
            `DSQ_ST_S1: if (|match) state_next = `DSQ_ST_S2;
            `DSQ_ST_S2: if (|match) state_next = `DSQ_ST_S3;
            `DSQ_ST_S3: state_next = s3_target;
            `DSQ_ST_FINAL: state_next = `DSQ_ST_FINAL;
            default: state_next = `DSQ_ST_IDLE;
        endcase
        // disarm wins so software can always stop a run
        if (arm_wr && !i_wdata[0])
            state_next = `DSQ_ST_IDLE;
    end

    wire enter_final = (state_next == `DSQ_ST_FINAL) && (state_reg != `DSQ_ST_FINAL);
    wire any_match_ev = (state_reg != `DSQ_ST_IDLE) && (state_reg != `DSQ_ST_FINAL)
        && (|match);

    ////////////////////////////////////////////////////////////////////////
    // register writes and sequencer state
    wire wr_win = i_wr && win_hit;
    wire [1:0] dsel = woff[1] ? 2'd1 : 2'd0;
    always @(posedge i_mclk) begin
        if (!i_rst_n) begin
            ctrl1_reg <= `DSQ_RST_BYTE;
            scr3_reg <= `DSQ_RST_SCR3;
            state_reg <= `DSQ_ST_IDLE;
            flags_reg <= 4'h0;
            irq_stat_reg <= 2'h0;
            irq_en_reg <= 2'h0;
            for (k = 0; k < 4; k = k + 1) begin
                ctl_reg[k] <= `DSQ_RST_BYTE;
                cadr_reg[k] <= {AW{1'b0}};
            end
            for (k = 0; k < 2; k = k + 1) begin
                cdat_reg[k] <= {DW{1'b0}};
                cmsk_reg[k] <= {DW{1'b0}};
            end
        end else if (i_ce) begin
            state_reg <= state_next;
            // match flags collect per channel in states 1 to 3, cleared on arm
            if (arm_wr && i_wdata[0])
                flags_reg <= 4'h0;
            else if (any_match_ev)
                flags_reg <= flags_reg | match;
            if (i_wr && i_addr == `DSQ_ADDR_CTRL1)
                ctrl1_reg <= i_wdata;
            // 0x27 writes only reach state3 control in the non-D views
            if (i_wr && i_addr == `DSQ_ADDR_SCR3 && view != 2'b11)
                scr3_reg <= i_wdata[3:0];
            if (i_wr && i_addr == `DSQ_ADDR_IRQ_EN)
                irq_en_reg <= i_wdata[1:0];
            // set wins over clear in the same cycle
            irq_stat_reg[`DSQ_IRQ_FINAL] <= enter_final ||
                (irq_stat_reg[`DSQ_IRQ_FINAL] &&
                 !(i_wr && i_addr == `DSQ_ADDR_IRQ_CLR && i_wdata[`DSQ_IRQ_FINAL]));
            irq_stat_reg[`DSQ_IRQ_MATCH] <= any_match_ev ||
                (irq_stat_reg[`DSQ_IRQ_MATCH] &&
                 !(i_wr && i_addr == `DSQ_ADDR_IRQ_CLR && i_wdata[`DSQ_IRQ_MATCH]));
            if (wr_win) begin
                case (woff)
                    `DSQ_WIN_CTL: ctl_reg[view] <= i_wdata &
                        (view_ac ? `DSQ_CTLAC_MASK : `DSQ_CTLBD_MASK);
                    `DSQ_WIN_ADDR_HI: cadr_reg[view][AW-1:16] <= i_wdata[AW-17:0];
                    `DSQ_WIN_ADDR_MD: cadr_reg[view][15:8] <= i_wdata;
                    `DSQ_WIN_ADDR_LO: cadr_reg[view][7:0] <= i_wdata;
                    `DSQ_WIN_DATA_HI, `DSQ_WIN_DATA_LO: begin
                        if (view_ac) begin
                            if (woff[0]) cdat_reg[ac_idx][7:0] <= i_wdata;
                            else cdat_reg[ac_idx][DW-1:8] <= i_wdata[DW-9:0];
                        end
                    end
                    default: begin
                        if (view_ac) begin
                            if (woff[0]) cmsk_reg[ac_idx][7:0] <= i_wdata;
                            else cmsk_reg[ac_idx][DW-1:8] <= i_wdata[DW-9:0];
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; data and mask bytes read zero for B and D
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (win_hit) begin
            case (woff)
                `DSQ_WIN_CTL: rd_mux = ctl_reg[view];
                `DSQ_WIN_ADDR_HI: rd_mux = cadr_reg[view][AW-1:16];
                `DSQ_WIN_ADDR_MD: rd_mux = cadr_reg[view][15:8];
                `DSQ_WIN_ADDR_LO: rd_mux = cadr_reg[view][7:0];
                `DSQ_WIN_DATA_HI: rd_mux = view_ac ? cdat_reg[ac_idx][DW-1:8] : 8'h00;
                `DSQ_WIN_DATA_LO: rd_mux = view_ac ? cdat_reg[ac_idx][7:0] : 8'h00;
                `DSQ_WIN_MASK_HI: rd_mux = view_ac ? cmsk_reg[ac_idx][DW-1:8] : 8'h00;
                default: rd_mux = view_ac ? cmsk_reg[ac_idx][7:0] : 8'h00;
            endcase
        end else begin
            case (i_addr)
                `DSQ_ADDR_CTRL1: rd_mux = ctrl1_reg;
                `DSQ_ADDR_ARM: rd_mux = {7'h00, state_reg != `DSQ_ST_IDLE};
                `DSQ_ADDR_STATE: rd_mux = {3'h0, state_reg};
                `DSQ_ADDR_IRQ_STAT: rd_mux = {6'h00, irq_stat_reg};
                `DSQ_ADDR_IRQ_EN: rd_mux = {6'h00, irq_en_reg};
                `DSQ_ADDR_SCR3: rd_mux = (view == 2'b11) ? {4'h0, flags_reg}
                    : {4'h0, scr3_reg};
                default: rd_mux = 8'h00;
            endcase
        end
    end

    // read data stand in the cycle after the strobe only
    always @(posedge i_mclk) begin
        if (!i_rst_n)
            o_rdata <= 8'h00;
        else if (i_ce)
            o_rdata <= i_rd ? rd_mux : 8'h00;
    end

    assign o_state = state_reg;
    assign o_final = state_reg == `DSQ_ST_FINAL;
    assign o_irq = |(irq_stat_reg & irq_en_reg);

endmodule
`default_nettype wire

// ===== tb/debug_state3_sequencer_comparators_tb.sv
// self-checking bench for the state3 sequencer and comparator window
`timescale 1ns/1ps
`default_nettype none
module debug_state3_sequencer_comparators_tb;
    logic i_mclk, o_final, o_irq;
    logic i_rst_n = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_bus_valid = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [7:0] i_wdata = 8'h00;
    logic [23:0] i_bus_addr = 24'h000000;
    logic [15:0] i_bus_data = 16'h0000;
    logic i_bus_rnw = 1'b1;
    logic [7:0] o_rdata;
    logic [4:0] o_state;
    int miscompares = 0;
    int total_checks = 0;
    // rows: code, enabled channel mask, expected state after the state3 match
    logic [15:0] rows [28] = '{16'h0802, 16'h1404, 16'h2210,
        16'h3102, 16'h3208, 16'h4104, 16'h5110, 16'h5E08,
        16'h6202, 16'h7204, 16'h8210, 16'h8108,
        16'h9404, 16'h9110, 16'h9510, 16'h9208,
        16'hA202, 16'hA804, 16'hAA02, 16'hB804, 16'hB210, 16'hBA10,
        16'hC410, 16'hC808, 16'hD810, 16'hEF08, 16'hFF08, 16'h0F02};

    // bus data stays quiet until the data compare test drives it, direction until the qualifier test
    dsq_seq #(.AW(24), .DW(16)) u_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_bus_valid(i_bus_valid), .i_bus_addr(i_bus_addr), .i_bus_data(i_bus_data),
        .i_bus_rnw(i_bus_rnw), .o_state(o_state), .o_final(o_final), .o_irq(o_irq));

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    //////////////////////////////////////////////////
    task chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // strobes drop for a cycle between accesses so no signal is driven twice per step
    task wr(input logic [7:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        @(posedge i_mclk);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
        @(posedge i_mclk);
    endtask
    task pulse(input logic [23:0] a);
        i_bus_addr <= a;
        i_bus_valid <= 1'b1;
        @(posedge i_mclk);
        i_bus_valid <= 1'b0;
        @(posedge i_mclk);
    endtask
    task set_en(input logic [3:0] m);
        for (int k = 0; k < 4; k++) begin
            wr(8'h20, k[7:0]);
            wr(8'h28, {7'h0, m[k]});
        end
        wr(8'h20, 8'h00);
    endtask
    task run(input logic [15:0] r);
        set_en(r[11:8]);
        wr(8'h27, {4'h0, r[15:12]});
        wr(8'h21, 8'h00);
        wr(8'h21, 8'h01);
        pulse(24'h123456);
        pulse(24'h123456);
        chk(o_state, 8'h08);
        pulse(24'h123456);
        chk(o_state, r[7:0]);
        chk(o_final, {7'h0, r[4]});
    endtask
    task end_of_test;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    //////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge i_mclk);
        chk({o_state, o_final, o_irq, 1'b0}, 8'h08);
        i_rst_n <= 1'b1;
        // same compare address in every bank so several channels can match at once
        for (int k = 0; k < 4; k++) begin
            wr(8'h20, k[7:0]);
            wr(8'h29, 8'h12);
            wr(8'h2A, 8'h34);
            wr(8'h2B, 8'h56);
            wr(8'h2C, 8'hAA);
            rd(8'h2C, k[0] ? 8'h00 : 8'hAA);
            wr(8'h28, 8'hFF);
            rd(8'h28, k[0] ? 8'h0D : 8'h0F);
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h20, k[7:0]);
            rd(8'h2B, 8'h56);
        end
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        $display("window test done");
        foreach (rows[i]) run(rows[i]);
        rd(8'h22, 8'h02);
        wr(8'h20, 8'h03);
        rd(8'h27, 8'h0F);
        wr(8'h27, 8'h05);
        wr(8'h20, 8'h02);
        rd(8'h27, 8'h00);
        $display("table test done");
        wr(8'h25, 8'h03);
        wr(8'h24, 8'h01);
        run(16'h2110);
        chk(o_irq, 8'h01);
        rd(8'h23, 8'h03);
        wr(8'h24, 8'h00);
        chk(o_irq, 8'h00);
        wr(8'h24, 8'h01);
        wr(8'h25, 8'h01);
        rd(8'h23, 8'h02);
        chk(o_irq, 8'h00);
        $display("interrupt test done");
        set_en(4'h0);
        wr(8'h21, 8'h00);
        wr(8'h21, 8'h01);
        pulse(24'h123456);
        chk(o_state, 8'h02);
        set_en(4'h1);
        pulse(24'h123457);
        chk(o_state, 8'h02);
        pulse(24'h123456);
        chk(o_state, 8'h04);
        $display("enable test done");
        // comparator A with data compare: data high byte AA under an FF00 mask
        wr(8'h20, 8'h00);
        wr(8'h2E, 8'hFF);
        wr(8'h28, 8'h03);
        wr(8'h21, 8'h00);
        wr(8'h21, 8'h01);
        pulse(24'h123456);
        chk(o_state, 8'h02);
        i_bus_data <= 16'hAA00;
        pulse(24'h123456);
        chk(o_state, 8'h04);
        // direction qualifier: only writes may match now
        wr(8'h28, 8'h09);
        pulse(24'h123456);
        chk(o_state, 8'h04);
        i_bus_rnw <= 1'b0;
        pulse(24'h123456);
        chk(o_state, 8'h08);
        $display("qualifier test done");
        end_of_test;
    end
endmodule
`default_nettype wire

// ===== tb/dsq_seq_assertions.sv
// port checker for the state3 sequencer and comparator window
`timescale 1ns/1ps
`default_nettype none
module dsq_seq_assertions #(parameter AW = 24, parameter DW = 16) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic i_bus_valid,
    input wire logic [AW-1:0] i_bus_addr,
    input wire logic [DW-1:0] i_bus_data,
    input wire logic i_bus_rnw,
    input wire logic [4:0] o_state,
    input wire logic o_final,
    input wire logic o_irq
);
    logic [1:0] view_reg;
    logic [3:0] code_reg;
    logic arm_wr;
    assign arm_wr = i_ce && i_wr && i_addr == 8'h21;
    // shadow of view and code; bd_zero_a depends on the view, reserved_hold_a on the code
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            view_reg <= 2'h0;
            code_reg <= 4'h0;
        end else if (i_ce && i_wr) begin
            if (i_addr == 8'h20) view_reg <= i_wdata[1:0];
            if (i_addr == 8'h27 && view_reg != 2'h3) code_reg <= i_wdata[3:0];
        end
    end
    //////////////////////////////////////////////////
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    rdata_idle_a: assert property (i_ce && !i_rd |=> o_rdata == 8'h00)
        else $error("read data not idle");
    one_hot_a: assert property ($onehot(o_state))
        else $error("state not one-hot");
    final_flag_a: assert property (o_final == (o_state == 5'h10))
        else $error("final flag wrong");
    bd_zero_a: assert property (i_ce && i_rd && view_reg[0] && i_addr[7:2] == 6'h0B
        |=> o_rdata == 8'h00) else $error("data byte not zero");
    state_read_a: assert property (i_ce && i_rd && i_addr == 8'h22
        |=> o_rdata == {3'h0, $past(o_state)}) else $error("state read wrong");
    final_hold_a: assert property (o_final && !arm_wr |=> o_final)
        else $error("final state left");
    reserved_hold_a: assert property (o_state == 5'h08 && code_reg[3:1] == 3'h7
        && !arm_wr |=> o_state == 5'h08) else $error("reserved code moved");
    s3_quiet_a: assert property (o_state == 5'h08 && !i_bus_valid && !arm_wr
        |=> $stable(o_state)) else $error("state3 left without match");
    cover property ($rose(o_final));
    cover property (o_state == 5'h08 && i_bus_valid);
    cover property ($rose(o_irq));
endmodule

bind dsq_seq dsq_seq_assertions #(.AW(AW), .DW(DW)) u_chk (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_bus_valid(i_bus_valid), .i_bus_addr(i_bus_addr),
    .i_bus_data(i_bus_data), .i_bus_rnw(i_bus_rnw), .o_state(o_state),
    .o_final(o_final), .o_irq(o_irq));
`default_nettype wire
